// file: design/fsp_pkg.sv
/*
 * constants, field layout and carrier types for the fan pwm block.
 * assumes a 32-bit apb3 master and single-cycle tick inputs in the core clock domain.
 */
// Summary of operation
// (RULE1) 8-bit counter wraps, 256 ticks per period
// (RULE2) pulse high while count below duty
// (RULE3) duty zero always low, all ones high; the code still drives duty zero high under overtemperature force
// (RULE4) invert bit flips pulse onto fan output
// (RULE5) counter clock from fast or slow input
// (RULE6) divide by pre-scale field plus one
// (RULE7) software keeps division between 1 and 124
// (RULE8) output rate is input over (ps+1)*256
// (RULE9) fast input clock selected after reset
// (RULE10) software sets rate first, then duty only
// (RULE11) no pre-scale writes while generator enabled
// (RULE12) overtemperature with fan enable forces full duty
// (RULE13) pre-scale bit 7 picks slow input clock
// (RULE14) software avoids pre-scale field 7Ch..7Fh
// (RULE15) counter steps on divided tick, live duty
// (RULE16) disabled generator holds divider, counter zero
package fsp_pkg;
    localparam int NUM_FAN = 3; // independent fan channels
    localparam int TEMP_CH = 2; // temperature channels reporting overtemperature
    localparam int AW = 8; // apb byte address width
    // nominal input clock rates, the ticks arrive on fast_tick_i / slow_tick_i
    localparam int FAST_CLK_HZ = 24000000;
    localparam int SLOW_CLK_HZ = 200000;
    // register byte addresses
    localparam logic [AW-1:0] PS_BASE = 8'h00; // pwm_prescale_reg, one word per fan
    localparam logic [AW-1:0] DUTY_BASE = 8'h10; // pwm_duty_reg, one word per fan
    localparam logic [AW-1:0] CTRL_ADDR = 8'h20; // enable and invert bits
    localparam logic [AW-1:0] OTCFG_ADDR = 8'h24; // overtemperature enable bits
    localparam logic [AW-1:0] STAT_ADDR = 8'h28; // read-only live state
    localparam logic [AW-1:0] BANK_MASK = 8'hF0; // selects the per-fan bank
    // field positions
    localparam int PS_SEL_BIT = 7; // clock select inside pwm_prescale_reg
    localparam int CTRL_EN_LSB = 0; // enable bits 2..0
    localparam int CTRL_INV_LSB = 4; // invert bits 6..4
    localparam int OT_EN_LSB = 0; // fan enable on overtemperature, bits 2..0
    localparam int ST_OUT_LSB = 0; // live fan outputs
    localparam int ST_FRC_LSB = 4; // live force state
    localparam int ST_OT_LSB = 8; // live overtemperature flags
    // reset values and the full-duty code
    localparam logic [7:0] PS_RST = 8'h00;
    localparam logic [7:0] DUTY_RST = 8'hFF;
    localparam logic [7:0] DUTY_FULL = 8'hFF;

    // pre-scale register layout
    typedef struct packed {
        logic clk_sel; // 0 fast input, 1 slow input
        logic [6:0] value; // divider minus one
    } fsp_prescale_s;

    // per-fan counting state
    typedef struct packed {
        logic [6:0] div; // divider phase
        logic [7:0] cnt; // pwm counter
    } fsp_count_s;
endpackage : fsp_pkg

// file: design/fsp_fan_pwm.sv
/*
 * three-channel fan pwm generator with apb3 register access.
 * assumes fast_tick_i and slow_tick_i are one-cycle pulses, one per input clock period,
 * already in the core clock domain, and that over_temp_flag_i is synchronous.
 */
`timescale 1ns/1ps
module fsp_fan_pwm (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [fsp_pkg::AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic fast_tick_i,
    input wire logic slow_tick_i,
    input wire logic [fsp_pkg::TEMP_CH-1:0] over_temp_flag_i,
    output logic [fsp_pkg::NUM_FAN-1:0] fan_drive_out_o
);
    import fsp_pkg::*;

    fsp_prescale_s ps_r [NUM_FAN]; // pwm_prescale_reg per fan
    fsp_prescale_s ps_nxt [NUM_FAN];
    logic [7:0] duty_r [NUM_FAN]; // pwm_duty_reg per fan
    logic [7:0] duty_nxt [NUM_FAN];
    fsp_count_s cs_r [NUM_FAN]; // divider and counter
    fsp_count_s cs_nxt [NUM_FAN];
    logic [NUM_FAN-1:0] en_r, en_nxt; // generator enables
    logic [NUM_FAN-1:0] inv_r, inv_nxt; // output inversion
    logic [NUM_FAN-1:0] oten_r, oten_nxt; // force on overtemperature
    logic [NUM_FAN-1:0] pulse_r, pulse_nxt; // internal pwm pulse
    logic [NUM_FAN-1:0] out_r, out_nxt; // fan_drive_out
    logic [NUM_FAN-1:0] frc; // live force condition
    logic [NUM_FAN-1:0] wrap; // divider terminal tick
    logic [NUM_FAN-1:0] tick; // selected input clock tick
    logic [31:0] prdata_r, prdata_nxt;
    logic err_r, err_nxt;
    logic wr_en; // access phase write
    logic any_ot; // any channel hot

    // index of a fan word inside a bank, valid when below NUM_FAN
    function automatic logic [1:0] fan_idx(input logic [AW-1:0] a);
        fan_idx = a[3:2];
    endfunction : fan_idx

    // true for every address that decodes to a register
    function automatic logic is_mapped(input logic [AW-1:0] a);
        logic bank_hit;
        bank_hit = ((a & BANK_MASK) == PS_BASE) || ((a & BANK_MASK) == DUTY_BASE);
        if (a[1:0] != 2'b00) begin
            is_mapped = 1'b0;
        end else if (bank_hit) begin
            is_mapped = (fan_idx(a) < 2'(NUM_FAN));
        end else begin
            is_mapped = (a == CTRL_ADDR) || (a == OTCFG_ADDR) || (a == STAT_ADDR);
        end
    endfunction : is_mapped

    // zero-wait slave: every access completes in its first access cycle
    assign pready_o = 1'b1;
    // error shows only in access, so a bad address never stalls the bus
    assign pslverr_o = psel_i & penable_i & err_r;
    assign prdata_o = prdata_r;
    assign fan_drive_out_o = out_r;
    assign wr_en = psel_i & penable_i & pwrite_i & ~err_r;
    assign any_ot = |over_temp_flag_i;

    // next-state for registers, counters and outputs
    always_comb begin
        ps_nxt = ps_r;
        duty_nxt = duty_r;
        en_nxt = en_r;
        inv_nxt = inv_r;
        oten_nxt = oten_r;
        prdata_nxt = prdata_r;
        err_nxt = err_r;
        // read data and error latched in setup, so they stand through access
        if (psel_i && !penable_i) begin
            err_nxt = !is_mapped(paddr_i);
            prdata_nxt = 32'h0000_0000;
            if (!is_mapped(paddr_i)) begin
                prdata_nxt = 32'h0000_0000;
            end else if ((paddr_i & BANK_MASK) == PS_BASE) begin
                prdata_nxt[7:0] = ps_r[fan_idx(paddr_i)];
            end else if ((paddr_i & BANK_MASK) == DUTY_BASE) begin
                prdata_nxt[7:0] = duty_r[fan_idx(paddr_i)];
            end else if (paddr_i == CTRL_ADDR) begin
                prdata_nxt[CTRL_EN_LSB +: NUM_FAN] = en_r;
                prdata_nxt[CTRL_INV_LSB +: NUM_FAN] = inv_r;
            end else if (paddr_i == OTCFG_ADDR) begin
                prdata_nxt[OT_EN_LSB +: NUM_FAN] = oten_r;
            end else begin
                prdata_nxt[ST_OUT_LSB +: NUM_FAN] = out_r;
                prdata_nxt[ST_FRC_LSB +: NUM_FAN] = frc;
                prdata_nxt[ST_OT_LSB +: TEMP_CH] = over_temp_flag_i;
            end
        end
        // writes land at the access edge; status writes are ignored
        if (wr_en) begin
            if ((paddr_i & BANK_MASK) == PS_BASE) begin
                ps_nxt[fan_idx(paddr_i)] = pwdata_i[7:0]; // see (RULE6) see (RULE13)
            end else if ((paddr_i & BANK_MASK) == DUTY_BASE) begin
                duty_nxt[fan_idx(paddr_i)] = pwdata_i[7:0];
            end else if (paddr_i == CTRL_ADDR) begin
                en_nxt = pwdata_i[CTRL_EN_LSB +: NUM_FAN];
                inv_nxt = pwdata_i[CTRL_INV_LSB +: NUM_FAN];
            end else if (paddr_i == OTCFG_ADDR) begin
                oten_nxt = pwdata_i[OT_EN_LSB +: NUM_FAN];
            end
        end
        // per-fan divider, counter and pulse shaping
        for (int i = 0; i < NUM_FAN; i++) begin
            cs_nxt[i] = cs_r[i];
            // selected input clock tick drives the divider
            tick[i] = ps_r[i].clk_sel ? slow_tick_i : fast_tick_i; // see (RULE5) see (RULE13)
            wrap[i] = tick[i] && (cs_r[i].div == ps_r[i].value); // see (RULE6) see (RULE8)
            if (!en_r[i]) begin
                cs_nxt[i] = '0; // known phase on enable, see (RULE16)
            end else if (wrap[i]) begin
                cs_nxt[i].div = 7'h00;
                cs_nxt[i].cnt = cs_r[i].cnt + 8'h01; // free-running wrap, see (RULE1) see (RULE15)
            end else if (tick[i]) begin
                cs_nxt[i].div = cs_r[i].div + 7'h01;
            end
            // overtemperature overrides duty and enable
            frc[i] = oten_r[i] & any_ot; // see (RULE12)
            // full duty is a special case, count below FFh would miss one tick
            pulse_nxt[i] = frc[i] | (en_r[i] & ((duty_r[i] == DUTY_FULL) // see (RULE3)
                | (cs_r[i].cnt < duty_r[i]))); // see (RULE2) see (RULE15)
            out_nxt[i] = pulse_nxt[i] ^ inv_r[i]; // see (RULE4)
        end
    end

    // register stage only
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            // constants only; counting restarts from zero once enabled
            for (int i = 0; i < NUM_FAN; i++) begin
                ps_r[i] <= PS_RST; // fast clock default, see (RULE9)
                duty_r[i] <= DUTY_RST;
                cs_r[i] <= '0;
            end
            en_r <= '0;
            inv_r <= '0;
            oten_r <= '0;
            pulse_r <= '0;
            out_r <= '0;
            prdata_r <= 32'h0000_0000;
            err_r <= 1'b0;
        end else begin
            ps_r <= ps_nxt;
            duty_r <= duty_nxt;
            cs_r <= cs_nxt;
            en_r <= en_nxt;
            inv_r <= inv_nxt;
            oten_r <= oten_nxt;
            pulse_r <= pulse_nxt;
            out_r <= out_nxt;
            prdata_r <= prdata_nxt;
            err_r <= err_nxt;
        end
    end

    // per-fan checks
    for (genvar g = 0; g < NUM_FAN; g++) begin : g_chk
        counter_wrap_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see (RULE1)
            (en_r[g] && wrap[g] && cs_r[g].cnt == 8'hFF) |=> (cs_r[g].cnt == 8'h00))
            else $error("pwm counter did not wrap to zero");
        count_compare_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see (RULE2)
            (en_r[g] && !frc[g] && duty_r[g] != DUTY_FULL)
            |=> (pulse_r[g] == ($past(cs_r[g].cnt) < $past(duty_r[g]))))
            else $error("pulse does not follow count against duty");
        duty_zero_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see (RULE3)
            (!frc[g] && duty_r[g] == 8'h00) [*3] |=> !pulse_r[g])
            else $error("zero duty let the pulse rise");
        duty_full_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see (RULE3)
            (en_r[g] && duty_r[g] == DUTY_FULL) |=> pulse_r[g])
            else $error("full duty let the pulse fall");
        out_invert_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see (RULE4)
            $stable(inv_r[g]) |-> (out_r[g] == (pulse_r[g] ^ $past(inv_r[g]))))
            else $error("fan output polarity wrong");
        tick_only_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see (RULE15)
            (en_r[g] && !wrap[g]) |=> (cs_r[g].cnt == $past(cs_r[g].cnt)))
            else $error("counter moved without divided tick");
        div_limit_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see (RULE6)
            (en_r[g] && $stable(ps_r[g])) |-> (cs_r[g].div <= ps_r[g].value))
            else $error("divider ran past pre-scale value");
        over_temp_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see (RULE12)
            (oten_r[g] && any_ot) |=> pulse_r[g])
            else $error("overtemperature did not force full duty");
        idle_hold_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see (RULE16)
            !en_r[g] |=> (cs_r[g].cnt == 8'h00 && cs_r[g].div == 7'h00))
            else $error("disabled generator kept counting");
        reset_sel_a: assert property (@(posedge core_clk_i) // see (RULE9)
            $rose(rstn_i) |-> (!ps_r[g].clk_sel && duty_r[g] == DUTY_RST))
            else $error("reset did not select fast clock");
        // slow source chosen: only a slow tick may move the divider
        slow_only_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see (RULE13)
            (en_r[g] && ps_r[g].clk_sel && !slow_tick_i) |=> $stable(cs_r[g]))
            else $error("divider moved without a slow tick");
        // every terminal tick advances the counter by exactly one
        count_step_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see (RULE15)
            (en_r[g] && wrap[g]) |=> (cs_r[g].cnt == $past(cs_r[g].cnt) + 8'h01))
            else $error("counter did not step on divided tick");
        // divider climbs one per selected tick below its terminal value
        div_step_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see (RULE6)
            (en_r[g] && tick[g] && cs_r[g].div != ps_r[g].value)
            |=> (cs_r[g].div == $past(cs_r[g].div) + 7'h01))
            else $error("divider did not step on input tick");
        // idle channel without force keeps its pulse low
        idle_low_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see (RULE16)
            (!en_r[g] && !frc[g]) |=> !pulse_r[g])
            else $error("disabled generator drove a pulse");
        // idle channel output rests at its invert level
        idle_out_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see (RULE4)
            (!en_r[g] && !frc[g]) |=> (out_r[g] == $past(inv_r[g])))
            else $error("idle fan output not at invert level");
    end : g_chk

endmodule : fsp_fan_pwm

// file: design/README_dummy_removed.sv
`timescale 1ns/1ps

// file: tb/fsp_fan_model.sv
/*
 * fan-side meter: counts the core cycles that each fan drive line spends high.
 * assumes drive lines change only at core clock edges.
 */
`timescale 1ns/1ps
module fsp_fan_model (
    input wire logic core_clk_i,
    input wire logic clr_i,
    input wire logic [2:0] drive_i,
    output logic [2:0][15:0] hi_cnt_o
);
    // high time per fan since the last clear; no reset, cleared by the bench
    always_ff @(posedge core_clk_i) begin
        for (int i = 0; i < 3; i++) begin
            if (clr_i) begin
                hi_cnt_o[i] <= 16'h0000;
            end else if (drive_i[i]) begin
                hi_cnt_o[i] <= hi_cnt_o[i] + 16'h0001;
            end
        end
    end
endmodule : fsp_fan_model

// file: tb/test_fsp_fan_pwm.sv
/*
 * self-checking bench for the fan pwm block: apb register access and measured duty.
 * assumes fast ticks every core cycle, except where a scenario stops them.
 */
`timescale 1ns/1ps
module test_fsp_fan_pwm;
    import fsp_pkg::*;
    logic clk, rstn, psel, pen, pwr, fast, slow, clr; // bench-driven inputs
    logic [AW-1:0] addr;
    logic [31:0] wdata, prdata, rd;
    logic pready, pslverr, err;
    logic [1:0] ot; // overtemperature flags
    logic [1:0] sdiv; // slow tick spacing counter
    logic [2:0] fan;
    logic [2:0][15:0] hi;
    int num_errors = 0;
    int n_tests = 0;
    fsp_fan_pwm u_dut (.core_clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .fast_tick_i(fast), .slow_tick_i(slow),
        .over_temp_flag_i(ot), .fan_drive_out_o(fan));
    fsp_fan_model u_fan (.core_clk_i(clk), .clr_i(clr), .drive_i(fan), .hi_cnt_o(hi));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // slow input clock: one tick every fourth core cycle, phase fixed by reset
    always @(posedge clk) begin
        if (!rstn) begin
            sdiv <= 2'h0;
            slow <= 1'b0;
        end else begin
            sdiv <= sdiv + 2'h1;
            slow <= (sdiv == 2'h3);
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; holds the request until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // no cycle budget of its own; only the watchdog ends a stuck wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    // high cycles of one fan over a window of n cycles
    task automatic meas(input int f, input int n, input logic [15:0] exp);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (n) @(posedge clk);
        #1 chk({16'h0000, hi[f]}, {16'h0000, exp});
    endtask : meas
    task automatic t_reset;
        apb(1'b0, PS_BASE, 32'h0);
        chk(rd, 32'h00000000);
        apb(1'b0, DUTY_BASE, 32'h0);
        chk(rd, 32'h000000FF);
        apb(1'b0, 8'h30, 32'h0);
        chk({31'h0, err}, 32'h00000001);
        $display("test reset done");
    endtask : t_reset
    task automatic t_duty;
        logic [7:0] dv[6] = '{8'h00, 8'h01, 8'h02, 8'h80, 8'hFE, 8'hFF};
        logic [15:0] ex[6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0080, 16'h00FE, 16'h0100};
        apb(1'b1, CTRL_ADDR, 32'h00000001); // rate set before enable
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, DUTY_BASE, {24'h0, dv[i]});
            meas(0, 256, ex[i]);
        end
        apb(1'b1, DUTY_BASE, 32'h00000002);
        apb(1'b1, CTRL_ADDR, 32'h00000011);
        meas(0, 256, 16'h00FE);
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk(rd, 32'h00000011);
        $display("test duty done");
    endtask : t_duty
    task automatic t_scale;
        apb(1'b1, CTRL_ADDR, 32'h0); // disabled before pre-scale writes
        meas(0, 16, 16'h0000);
        apb(1'b1, PS_BASE, 32'h00000001);
        apb(1'b1, DUTY_BASE, 32'h00000003);
        apb(1'b1, CTRL_ADDR, 32'h00000001);
        meas(0, 512, 16'h0006);
        apb(1'b1, CTRL_ADDR, 32'h0);
        apb(1'b1, PS_BASE, 32'h0000007B); // largest legal divider
        apb(1'b1, DUTY_BASE, 32'h00000001);
        apb(1'b1, CTRL_ADDR, 32'h00000001);
        meas(0, 31744, 16'h007C);
        apb(1'b1, CTRL_ADDR, 32'h0);
        // fast ticks stop, so a wrong source would freeze the count at zero and hold the output high
        fast <= 1'b0;
        apb(1'b1, PS_BASE, 32'h00000080);
        apb(1'b1, DUTY_BASE, 32'h00000005);
        apb(1'b1, CTRL_ADDR, 32'h00000001);
        meas(0, 1024, 16'h0014);
        @(posedge clk);
        fast <= 1'b1;
        $display("test scale done");
    endtask : t_scale
    task automatic t_hot;
        apb(1'b1, DUTY_BASE, 32'h0);
        apb(1'b1, OTCFG_ADDR, 32'h00000001);
        @(posedge clk);
        ot <= 2'b10;
        meas(0, 1024, 16'h0400);
        chk({16'h0000, hi[1]}, 32'h00000000);
        apb(1'b0, STAT_ADDR, 32'h0);
        chk(rd, 32'h00000211);
        apb(1'b1, OTCFG_ADDR, 32'h0);
        meas(0, 1024, 16'h0000);
        $display("test overtemperature done");
    endtask : t_hot
    task automatic print_verdict;
        $display("errors %0d compares %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    initial begin
        {rstn, psel, pen, pwr, clr} = 5'b00000;
        fast = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        ot = 2'b00;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_duty();
        t_scale();
        t_hot();
        print_verdict();
    end
    // cuts a hang short well beyond the expected run
    initial begin
        #3000000;
        num_errors++;
        print_verdict();
    end
endmodule : test_fsp_fan_pwm
